// *** msf_pkg.sv ***
// Constants, register map and modem state codes for the modem status and FIFO port block
package msf_pkg;
  // ---------------------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS2  = 8'h08;
  localparam logic [7:0] IDX_FIFO     = 8'h09;
  localparam logic [7:0] IDX_LEVEL    = 8'h10;
  localparam logic [7:0] IDX_CTRL     = 8'h11;
  localparam logic [7:0] IDX_TX_GUARD = 8'h12;
  localparam logic [7:0] IDX_RX_GUARD = 8'h13;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h14;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h15;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned S2_TEMP_CLR   = 7;
  localparam int unsigned S2_FORCE_FAST = 6;
  localparam int unsigned S2_TARGET     = 4;
  localparam int unsigned S2_CIPHER     = 3;
  localparam int unsigned CTRL_LAUNCH   = 0;
  localparam int unsigned CTRL_TX_WAIT  = 1;
  localparam int unsigned CTRL_RX_WAIT  = 2;
  localparam int unsigned IRQ_OVFL      = 0;
  localparam int unsigned IRQ_TX_DONE   = 1;
  localparam int unsigned IRQ_RX_DONE   = 2;
  localparam int unsigned IRQ_TARGET    = 3;
  localparam int unsigned IRQ_W         = 4;
  // ---------------------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------------------
  localparam logic [7:0]       STATUS2_RST  = 8'h00;
  localparam logic [7:0]       GUARD_RST    = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST      = 4'h0;
  localparam int unsigned      FIFO_DEPTH   = 64;
  // ---------------------------------------------------------------------------
  // Timing: guard settings count ticks of this period
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned GUARD_TICK_NS = 160;
  localparam int unsigned GUARD_TICK_CYC = (GUARD_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ---------------------------------------------------------------------------
  // Modem state codes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MS_IDLE      = 3'h0,
    MS_AWAIT     = 3'h1,
    MS_TX_WAIT   = 3'h2,
    MS_SEND      = 3'h3,
    MS_RX_WAIT   = 3'h4,
    MS_WAIT_DATA = 3'h5,
    MS_RECV      = 3'h6
  } msf_modem_t;
endpackage : msf_pkg

// *** msf_rf_model.sv ***
// Far-side RF engine model: takes transmit bytes, answers with the inverted bytes
module msf_rf_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Modem state and byte streams
  input  wire logic [2:0] modem_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o = 1'b0,
  output logic            tx_done_o  = 1'b0,
  output logic      [7:0] rx_byte_o  = 8'h00,
  output logic            rx_valid_o = 1'b0,
  input  wire logic       rx_ready_i,
  output logic            rx_start_o = 1'b0,
  output logic            rx_end_o   = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  int         k    = 0;
  int         idle = 0;
  // Ready toggles so the transmit side always sees stalls; idle rx line never holds a value
  always @(posedge clk_i) begin
    int nk;
    nk = k + int'(rx_valid_o && rx_ready_i);
    if (tx_valid_i && tx_ready_o) got.push_back(tx_byte_i);
    tx_ready_o <= ~tx_ready_o & ~rst_i;
    idle       <= (modem_i == 3'h3 && !tx_valid_i) ? idle + 1 : 0;
    tx_done_o  <= (idle == 3);
    rx_start_o <= (modem_i == 3'h5) && !rx_start_o;
    k          <= (modem_i == 3'h6) ? nk : 0;
    rx_valid_o <= (modem_i == 3'h6) && nk < got.size();
    rx_byte_o  <= (modem_i == 3'h6 && nk < got.size()) ? ~got[nk] : ~rx_byte_o;
    rx_end_o   <= (modem_i == 3'h6) && nk >= got.size() && !rx_end_o;
    if (rst_i) got.delete();
  end
endmodule : msf_rf_model

// *** msf_top.sv ***
// Secondary status register, FIFO byte port, modem sequencer and Wishbone slave
// Overview of operation
// - Writing one to temp_alarm_clear clears temperature error only when below the limit.
// - Force bit selects fast bus filter; otherwise filter follows the protocol in use.
// - Passive target flag sets when a select or polling command is answered.
// - That flag sets only during automatic anticollision in passive mode.
// - Passive target flag clears when the external RF field switches off.
// - While cipher flag is one, card traffic goes through the stream cipher.
// - Cipher flag sets only on successful authentication in reader mode; software clears.
// - Read-only 3-bit modem state field with the seven documented codes.
// - Transmit wait lasts the tx guard time and optionally waits for field.
// - Receive wait lasts the rx guard time and optionally waits for field.
// - Status register at index 08h, all bits reset to zero, bit 5 reserved.
// - Byte port at index 09h writes and reads the internal 64-byte FIFO.
// - The FIFO buffers bytes between registers and serial transmit and receive.
// - Fill count adds one per push (port write to a non-full FIFO, or rx byte) and subtracts one per pop (port read of a non-empty one, or tx byte).
// - Launch bit starts transmission only from the awaiting-launch state of transceive.
module msf_top #(
  parameter int unsigned DEPTH = msf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  // Environment and command status
  input  wire logic        temp_alarm_i,
  input  wire logic        temp_below_limit_i,
  input  wire logic        protocol_fast_i,
  input  wire logic        field_present_i,
  input  wire logic        auto_anticollision_cmd_i,
  input  wire logic        passive_mode_i,
  input  wire logic        target_answered_i,
  input  wire logic        cipher_auth_ok_i,
  input  wire logic        reader_mode_i,
  input  wire logic        transceive_cmd_i,
  output logic             temp_err_o,
  output logic             filter_fast_o,
  output logic             cipher_enable_o,
  output logic      [2:0]  modem_state_o,
  // Transmit byte stream
  output logic      [7:0]  tx_byte_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  input  wire logic        tx_done_i,
  // Receive byte stream
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_valid_i,
  output logic             rx_ready_o,
  input  wire logic        rx_start_i,
  input  wire logic        rx_end_i
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned TW = $clog2(msf_pkg::GUARD_TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(msf_pkg::GUARD_TICK_CYC - 1);
  localparam logic [PW:0]   FULL_CNT  = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][7:0]          mem;
    logic [PW-1:0]                  wr_ptr;
    logic [PW-1:0]                  rd_ptr;
    logic [PW:0]                    count;
    logic                           temp_err;
    logic                           temp_clr;
    logic                           force_fast;
    logic                           target_sel;
    logic                           cipher_on;
    msf_pkg::msf_modem_t            modem;
    logic                           tx_wait_rf;
    logic                           rx_wait_rf;
    logic [7:0]                     tx_guard;
    logic [7:0]                     rx_guard;
    logic [7:0]                     guard_cnt;
    logic [TW-1:0]                  tick_cnt;
    logic [msf_pkg::IRQ_W-1:0]      irq_stat;
    logic [msf_pkg::IRQ_W-1:0]      irq_mask;
    logic                           field_q;
    logic                           ack;
    logic [31:0]                    dat;
  } msf_state_t;

  msf_state_t st_reg;
  msf_state_t st_next;

  // Address decode shared by every register access
  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    hit = (adr[9:2] == idx);
  endfunction : hit

  logic       bus_op;
  logic       bus_wr;
  logic       wr_fifo;
  logic       rd_fifo;
  logic       full;
  logic       empty;
  logic       push;
  logic       pop;
  logic       rx_push;
  logic       tx_pop;
  logic       tick;
  logic       launch;
  logic       target_set;
  logic       cipher_set;
  logic [7:0] rdata;

  // ---------------------------------------------------------------------------
  // Request decode and FIFO arbitration
  // ---------------------------------------------------------------------------
  // Side effects happen once, on the cycle the ack is being raised
  assign bus_op  = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign bus_wr  = bus_op & wb_we_i & wb_sel_i[0];
  assign wr_fifo = bus_wr & hit(wb_adr_i, msf_pkg::IDX_FIFO);
  assign rd_fifo = bus_op & ~wb_we_i & hit(wb_adr_i, msf_pkg::IDX_FIFO);
  assign full    = (st_reg.count == FULL_CNT);
  assign empty   = (st_reg.count == '0);
  // Bus access has priority; the engines simply stall one cycle
  assign rx_ready_o = (st_reg.modem == msf_pkg::MS_RECV) & ~full & ~wr_fifo;
  assign tx_valid_o = (st_reg.modem == msf_pkg::MS_SEND) & ~empty & ~rd_fifo;
  assign tx_byte_o  = st_reg.mem[st_reg.rd_ptr];
  assign rx_push = rx_valid_i & rx_ready_o;
  assign tx_pop  = tx_valid_o & tx_ready_i;
  assign push    = (wr_fifo & ~full) | rx_push;
  assign pop     = (rd_fifo & ~empty) | tx_pop;
  assign tick    = (st_reg.tick_cnt == TICK_LAST);
  assign launch  = bus_wr & hit(wb_adr_i, msf_pkg::IDX_CTRL)
                 & wb_dat_i[msf_pkg::CTRL_LAUNCH] & transceive_cmd_i;
  assign target_set = target_answered_i & auto_anticollision_cmd_i & passive_mode_i;
  assign cipher_set = cipher_auth_ok_i & reader_mode_i;

  // ---------------------------------------------------------------------------
  // Read data mux
  // ---------------------------------------------------------------------------
  always_comb begin
    rdata = 8'h00;
    if (hit(wb_adr_i, msf_pkg::IDX_STATUS2)) begin
      rdata = {st_reg.temp_clr, st_reg.force_fast, 1'b0, st_reg.target_sel,
               st_reg.cipher_on, st_reg.modem};
    end else if (hit(wb_adr_i, msf_pkg::IDX_FIFO)) begin
      rdata = empty ? 8'h00 : st_reg.mem[st_reg.rd_ptr];
    end else if (hit(wb_adr_i, msf_pkg::IDX_LEVEL)) begin
      rdata = 8'(st_reg.count);
    end else if (hit(wb_adr_i, msf_pkg::IDX_CTRL)) begin
      rdata = {5'h00, st_reg.rx_wait_rf, st_reg.tx_wait_rf, 1'b0};
    end else if (hit(wb_adr_i, msf_pkg::IDX_TX_GUARD)) begin
      rdata = st_reg.tx_guard;
    end else if (hit(wb_adr_i, msf_pkg::IDX_RX_GUARD)) begin
      rdata = st_reg.rx_guard;
    end else if (hit(wb_adr_i, msf_pkg::IDX_IRQ_STAT)) begin
      rdata = {4'h0, st_reg.irq_stat};
    end else if (hit(wb_adr_i, msf_pkg::IDX_IRQ_MASK)) begin
      rdata = {4'h0, st_reg.irq_mask};
    end
  end

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.ack      = bus_op;
    st_next.field_q  = field_present_i;
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + TW'(1);
    if (bus_op) begin
      st_next.dat = {24'h000000, rdata};
    end
    // FIFO pointers and fill count
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = wr_fifo ? wb_dat_i[7:0] : rx_byte_i;
      st_next.wr_ptr = st_reg.wr_ptr + PW'(1);
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + PW'(1);
    end
    st_next.count = st_reg.count + (PW+1)'(push) - (PW+1)'(pop);
    // Register writes
    if (bus_wr && hit(wb_adr_i, msf_pkg::IDX_STATUS2)) begin
      st_next.temp_clr   = wb_dat_i[msf_pkg::S2_TEMP_CLR];
      st_next.force_fast = wb_dat_i[msf_pkg::S2_FORCE_FAST];
      if (wb_dat_i[msf_pkg::S2_TEMP_CLR] && temp_below_limit_i) begin
        st_next.temp_err = 1'b0;
      end
      if (!wb_dat_i[msf_pkg::S2_CIPHER]) begin
        st_next.cipher_on = 1'b0;
      end
    end
    if (bus_wr && hit(wb_adr_i, msf_pkg::IDX_CTRL)) begin
      st_next.tx_wait_rf = wb_dat_i[msf_pkg::CTRL_TX_WAIT];
      st_next.rx_wait_rf = wb_dat_i[msf_pkg::CTRL_RX_WAIT];
    end
    if (bus_wr && hit(wb_adr_i, msf_pkg::IDX_TX_GUARD)) begin
      st_next.tx_guard = wb_dat_i[7:0];
    end
    if (bus_wr && hit(wb_adr_i, msf_pkg::IDX_RX_GUARD)) begin
      st_next.rx_guard = wb_dat_i[7:0];
    end
    if (bus_wr && hit(wb_adr_i, msf_pkg::IDX_IRQ_STAT)) begin
      st_next.irq_stat = st_reg.irq_stat & ~wb_dat_i[msf_pkg::IRQ_W-1:0];
    end
    if (bus_wr && hit(wb_adr_i, msf_pkg::IDX_IRQ_MASK)) begin
      st_next.irq_mask = wb_dat_i[msf_pkg::IRQ_W-1:0];
    end
    // Hardware sets win over software clears
    if (st_reg.field_q && !field_present_i) begin
      st_next.target_sel = 1'b0;
    end
    if (target_set) begin
      st_next.target_sel = 1'b1;
      st_next.irq_stat[msf_pkg::IRQ_TARGET] = 1'b1;
    end
    if (cipher_set) begin
      st_next.cipher_on = 1'b1;
    end
    if (temp_alarm_i) begin
      st_next.temp_err = 1'b1;
    end
    if (wr_fifo && full) begin
      st_next.irq_stat[msf_pkg::IRQ_OVFL] = 1'b1;
    end
    // Guard counter saturates so long settings never wrap
    if (tick && st_reg.guard_cnt != 8'hFF) begin
      st_next.guard_cnt = st_reg.guard_cnt + 8'h01;
    end
    // Modem sequencer
    case (st_reg.modem)
      msf_pkg::MS_IDLE: begin
        if (transceive_cmd_i) begin
          st_next.modem = msf_pkg::MS_AWAIT;
        end
      end
      msf_pkg::MS_AWAIT: begin
        if (launch) begin
          st_next.modem     = msf_pkg::MS_TX_WAIT;
          st_next.guard_cnt = 8'h00;
          st_next.tick_cnt  = '0;                            // no short first tick
        end
      end
      msf_pkg::MS_TX_WAIT: begin
        if (st_reg.guard_cnt >= st_reg.tx_guard
            && (field_present_i || !st_reg.tx_wait_rf)) begin
          st_next.modem = msf_pkg::MS_SEND;
        end
      end
      msf_pkg::MS_SEND: begin
        if (tx_done_i) begin
          st_next.modem     = msf_pkg::MS_RX_WAIT;
          st_next.guard_cnt = 8'h00;
          st_next.tick_cnt  = '0;                            // no short first tick
          st_next.irq_stat[msf_pkg::IRQ_TX_DONE] = 1'b1;
        end
      end
      msf_pkg::MS_RX_WAIT: begin
        if (st_reg.guard_cnt >= st_reg.rx_guard
            && (field_present_i || !st_reg.rx_wait_rf)) begin
          st_next.modem = msf_pkg::MS_WAIT_DATA;
        end
      end
      msf_pkg::MS_WAIT_DATA: begin
        if (rx_start_i) begin
          st_next.modem = msf_pkg::MS_RECV;
        end
      end
      msf_pkg::MS_RECV: begin
        if (rx_end_i) begin
          st_next.modem = msf_pkg::MS_AWAIT;
          st_next.irq_stat[msf_pkg::IRQ_RX_DONE] = 1'b1;
        end
      end
      default: begin
        st_next.modem = msf_pkg::MS_IDLE;
      end
    endcase
    // Leaving the transceive command aborts any sequence
    if (!transceive_cmd_i) begin
      st_next.modem = msf_pkg::MS_IDLE;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg            <= '0;
      st_reg.modem      <= msf_pkg::MS_IDLE;
      st_reg.tx_guard   <= msf_pkg::GUARD_RST;
      st_reg.rx_guard   <= msf_pkg::GUARD_RST;
      st_reg.irq_mask   <= msf_pkg::IRQ_RST;
      st_reg.irq_stat   <= msf_pkg::IRQ_RST;
      {st_reg.temp_clr, st_reg.force_fast, st_reg.target_sel, st_reg.cipher_on}
                        <= msf_pkg::STATUS2_RST[3:0];
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign wb_ack_o        = st_reg.ack;
  assign wb_dat_o        = st_reg.dat;
  assign irq_o           = |(st_reg.irq_stat & st_reg.irq_mask);
  assign temp_err_o      = st_reg.temp_err;
  assign filter_fast_o   = st_reg.force_fast | protocol_fast_i;
  assign cipher_enable_o = st_reg.cipher_on;
  assign modem_state_o   = st_reg.modem;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_fifo_write_count: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fifo && !full && !tx_pop |=> st_reg.count == $past(st_reg.count) + 7'h01)
    else $error("fill count did not rise on port write");
  a_fifo_read_count: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_fifo && !empty && !rx_push |=> st_reg.count == $past(st_reg.count) - 7'h01)
    else $error("fill count did not fall on port read");
  a_full_write_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fifo && full && !tx_pop |=> st_reg.irq_stat[msf_pkg::IRQ_OVFL] && full)
    else $error("write to full queue not dropped or not flagged");
  a_target_only_auto: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_reg.target_sel) |-> $past(auto_anticollision_cmd_i && passive_mode_i))
    else $error("target flag set outside passive anticollision");
  a_target_field_off: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.field_q && !field_present_i && !target_set |=> !st_reg.target_sel)
    else $error("target flag survived field switch-off");
  a_cipher_set_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_reg.cipher_on) |-> $past(cipher_auth_ok_i && reader_mode_i))
    else $error("cipher flag set without authentication");
  a_temp_clear_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_wr && hit(wb_adr_i, msf_pkg::IDX_STATUS2) && st_reg.temp_err
    && !temp_below_limit_i |=> st_reg.temp_err)
    else $error("temperature error cleared while still hot");
  a_tx_guard_min: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.modem == msf_pkg::MS_TX_WAIT ##1 st_reg.modem == msf_pkg::MS_SEND
    |-> $past(st_reg.guard_cnt) >= $past(st_reg.tx_guard))
    else $error("transmit wait shorter than guard setting");
  a_rx_guard_min: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.modem == msf_pkg::MS_RX_WAIT ##1 st_reg.modem == msf_pkg::MS_WAIT_DATA
    |-> $past(st_reg.guard_cnt) >= $past(st_reg.rx_guard))
    else $error("receive wait shorter than guard setting");
  a_launch_start: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.modem == msf_pkg::MS_AWAIT && launch |=> st_reg.modem == msf_pkg::MS_TX_WAIT)
    else $error("launch did not start transmit wait");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
endmodule : msf_top

// *** tb_modem_status_and_fifo_port.sv ***
// Self-checking bench for the status register, FIFO port and modem sequencer
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_modem_status_and_fifo_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, irq_o, temp_err_o, filter_fast_o, cipher_enable_o, tx_valid_o, rx_ready_o;
  logic temp_alarm_i = 0, temp_below_limit_i = 0, protocol_fast_i = 0, field_present_i = 0;
  logic auto_anticollision_cmd_i = 0, passive_mode_i = 0, target_answered_i = 0;
  logic cipher_auth_ok_i = 0, reader_mode_i = 0, transceive_cmd_i = 0;
  logic [2:0] modem_state_o;
  logic [7:0] tx_byte_o, rx_byte_i, r;
  logic tx_ready_i, tx_done_i, rx_valid_i, rx_start_i, rx_end_i;
  logic [7:0] seen = 8'h00;
  logic [31:0] seed = 32'd24594;
  logic [7:0] exp_q[$];
  int fails = 0, comparisons = 0, cyc_n = 0, t4 = 0;

  msf_top #(.DEPTH(64)) dut (.*);
  msf_rf_model mdl (.clk_i(clk_i), .rst_i(rst_i), .modem_i(modem_state_o),
    .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
    .tx_done_o(tx_done_i), .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i),
    .rx_ready_i(rx_ready_o), .rx_start_o(rx_start_i), .rx_end_o(rx_end_i));

  // Clock, timeout and modem state bookkeeping
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    seen[modem_state_o] <= 1'b1;
    if (modem_state_o == 3'h4) t4 <= t4 + 1;
    if (cyc_n == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  function automatic logic exp_filter(input logic force_bit, input logic proto);
    return force_bit | proto;
  endfunction : exp_filter

  // Classic cycle: hold until ack is sampled high, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    // Only the bench timeout ends a wait for ack
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    `CHK(q, e)
  endtask : rdc
  // One-cycle event: 0 alarm, 1 anticollision command, else authentication
  task automatic pulse(input int unsigned which);
    case (which)
      0: temp_alarm_i <= 1'b1;
      1: auto_anticollision_cmd_i <= 1'b1;
      default: cipher_auth_ok_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {temp_alarm_i, auto_anticollision_cmd_i, cipher_auth_ok_i} <= 3'b000;
    @(posedge clk_i);
  endtask : pulse
  task automatic report_and_stop();
    $display("TB: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Main sequence: status bits, FIFO limits, a full transceive, interrupts
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(msf_pkg::IDX_STATUS2, 8'h00);
    wr(msf_pkg::IDX_STATUS2, 8'h20);
    rdc(msf_pkg::IDX_STATUS2, 8'h00);
    rdc(8'hFF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      protocol_fast_i <= i[0];
      wr(msf_pkg::IDX_STATUS2, {1'b0, i[1], 6'h00});
      `CHK(filter_fast_o, exp_filter(i[1], i[0]))
    end
    pulse(0);
    wr(msf_pkg::IDX_STATUS2, 8'h80);
    `CHK(temp_err_o, 1'b1)
    temp_below_limit_i <= 1'b1;
    wr(msf_pkg::IDX_STATUS2, 8'h80);
    `CHK(temp_err_o, 1'b0)
    wr(msf_pkg::IDX_STATUS2, 8'h00);
    {field_present_i, target_answered_i, passive_mode_i} <= 3'b111;
    repeat (3) @(posedge clk_i);
    rdc(msf_pkg::IDX_STATUS2, 8'h00);
    pulse(1);
    target_answered_i <= 1'b0;
    rdc(msf_pkg::IDX_STATUS2, 8'h10);
    field_present_i <= 1'b0;
    // Field drop clears the flag on the edge that first samples it low
    @(posedge clk_i);
    rdc(msf_pkg::IDX_STATUS2, 8'h00);
    pulse(2);
    `CHK(cipher_enable_o, 1'b0)
    reader_mode_i <= 1'b1;
    pulse(2);
    rdc(msf_pkg::IDX_STATUS2, 8'h08);
    `CHK(cipher_enable_o, 1'b1)
    wr(msf_pkg::IDX_STATUS2, 8'h00);
    `CHK(cipher_enable_o, 1'b0)
    // Fill past the top, then drain past the bottom
    for (int i = 0; i < 65; i++) begin
      r = rnd();
      if (i < 64) exp_q.push_back(r);
      wr(msf_pkg::IDX_FIFO, r);
    end
    rdc(msf_pkg::IDX_LEVEL, 8'd64);
    rdc(msf_pkg::IDX_IRQ_STAT, 8'h09);
    while (exp_q.size() > 0) rdc(msf_pkg::IDX_FIFO, exp_q.pop_front());
    rdc(msf_pkg::IDX_LEVEL, 8'd0);
    rdc(msf_pkg::IDX_FIFO, 8'h00);
    rdc(msf_pkg::IDX_LEVEL, 8'd0);
    wb_sel_i <= 4'h0;
    wr(msf_pkg::IDX_TX_GUARD, 8'h55);
    wb_sel_i <= 4'hF;
    rdc(msf_pkg::IDX_TX_GUARD, 8'h00);
    // Transceive with field wait on both sides
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      exp_q.push_back(r);
      wr(msf_pkg::IDX_FIFO, r);
    end
    wr(msf_pkg::IDX_CTRL, 8'h01);
    `CHK(modem_state_o, 3'h0)
    wr(msf_pkg::IDX_TX_GUARD, 8'h02);
    wr(msf_pkg::IDX_RX_GUARD, 8'h03);
    transceive_cmd_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(modem_state_o, 3'h1)
    wr(msf_pkg::IDX_CTRL, 8'h07);
    repeat (60) @(posedge clk_i);
    `CHK(modem_state_o, 3'h2)
    field_present_i <= 1'b1;
    for (int n = 0; n < 3000 && modem_state_o !== 3'h1; n++) @(posedge clk_i);
    `CHK(mdl.got.size(), 4)
    for (int i = 0; i < 4; i++) `CHK(mdl.got[i], exp_q[i])
    `CHK(t4 >= 3 * msf_pkg::GUARD_TICK_CYC, 1'b1)
    while (exp_q.size() > 0) rdc(msf_pkg::IDX_FIFO, ~exp_q.pop_front());
    transceive_cmd_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(seen, 8'h7F)
    `CHK(modem_state_o, 3'h0)
    // Interrupt: sticky status, mask, write-one clear
    rdc(msf_pkg::IDX_IRQ_STAT, 8'h0F);
    `CHK(irq_o, 1'b0)
    wr(msf_pkg::IDX_IRQ_MASK, 8'h04);
    `CHK(irq_o, 1'b1)
    wr(msf_pkg::IDX_IRQ_STAT, 8'h04);
    `CHK(irq_o, 1'b0)
    rdc(msf_pkg::IDX_IRQ_STAT, 8'h0B);
    report_and_stop();
  end
endmodule : tb_modem_status_and_fifo_port
